// File: verilog/als_readout.sv
/*
 * ambient light readout top: i2c target that serves the result
 * registers through an auto-incrementing pointer, plus the sequencer.
 * assumes scl and sda come from pins, sda is open drain, and the
 * control word and sample arrive on the clk domain.
 */
`timescale 1ns/100ps
`include "als_cfg.svh"

module als_readout #(
    parameter int unsigned FRAME_CYC = `ALS_FRAME_CYC,
    parameter int unsigned CONV_CYC  = `ALS_CONV_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output      logic               sda_out,
    output      logic               sda_oe,
    input  wire als_pkg::als_ctrl_t ctrl,
    input  wire logic [15:0]        sample,
    output      als_pkg::als_result_t result,
    output      logic               conv_active
);

    // ******************************************************************
    // register view
    // ******************************************************************
    // unmapped pointers read as a constant so the host never hangs
    function automatic logic [7:0] reg_byte(input logic [7:0]  ptr,
                                            input logic [15:0] res);
        if (ptr == `ALS_REG_RES_HI) begin
            reg_byte = res[15:8];
        end else if (ptr == `ALS_REG_RES_LO) begin
            reg_byte = res[7:0];
        end else begin
            reg_byte = `ALS_UNMAPPED_BYTE;
        end
    endfunction

    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    // bus lines idle high, so reset to high avoids a false start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // edges only from the second stage onward
    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ******************************************************************
    // measurement sequencer
    // ******************************************************************
    als_conv_seq #(
        .FRAME_CYC (FRAME_CYC),
        .CONV_CYC  (CONV_CYC)
    ) u_seq (
        .clk         (clk),
        .rst_b       (rst_b),
        .ctrl        (ctrl),
        .sample      (sample),
        .result      (result),
        .conv_active (conv_active)
    );

    // ******************************************************************
    // i2c target
    // ******************************************************************
    als_pkg::bus_state_t st_q, st_d;
    logic [7:0]          sh_q, sh_d;
    logic [7:0]          tx_q, tx_d;
    logic [2:0]          cnt_q, cnt_d;
    logic [7:0]          ptr_q, ptr_d;
    logic                rw_q, rw_d;
    logic                oe_q, oe_d;
    logic                got_ptr_q, got_ptr_d;
    logic [7:0]          sh_next;
    logic [7:0]          ld_byte;

    assign sda_out = 1'b0;   // open drain: only ever pulls low
    assign sda_oe  = oe_q;

    // ack phases use oe_q as a half-bit marker: first fall drives the
    // ack low; the next fall releases it, or after a read address drives
    // bit 7 of the first byte, and moves on
    always_comb begin
        st_d      = st_q;
        sh_d      = sh_q;
        tx_d      = tx_q;
        cnt_d     = cnt_q;
        ptr_d     = ptr_q;
        rw_d      = rw_q;
        oe_d      = oe_q;
        got_ptr_d = got_ptr_q;
        sh_next   = {sh_q[6:0], sda_s_q};
        ld_byte   = reg_byte(ptr_q, result.value);
        if (bus_start) begin
            st_d      = als_pkg::BUS_ADDR;
            cnt_d     = '0;
            oe_d      = 1'b0;
            got_ptr_d = 1'b0;
        end else if (bus_stop) begin
            st_d = als_pkg::BUS_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                als_pkg::BUS_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = sh_next;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            rw_d = sh_next[0];
                            st_d = (sh_next[7:1] == `ALS_I2C_ADDR7)
                                 ? als_pkg::BUS_ADDR_ACK
                                 : als_pkg::BUS_IDLE;
                        end
                    end
                end
                als_pkg::BUS_ADDR_ACK: begin
                    if (scl_fall && !oe_q) begin
                        oe_d = 1'b1;
                    end else if (scl_fall && rw_q) begin
                        tx_d  = ld_byte;
                        oe_d  = ~ld_byte[7];
                        cnt_d = '0;
                        st_d  = als_pkg::BUS_TX;
                    end else if (scl_fall) begin
                        oe_d  = 1'b0;
                        cnt_d = '0;
                        st_d  = als_pkg::BUS_RX;
                    end
                end
                als_pkg::BUS_RX: begin
                    if (scl_rise) begin
                        sh_d  = sh_next;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            // only the first byte is a pointer
                            if (!got_ptr_q) begin
                                ptr_d = sh_next;
                            end
                            got_ptr_d = 1'b1;
                            st_d      = als_pkg::BUS_RX_ACK;
                        end
                    end
                end
                als_pkg::BUS_RX_ACK: begin
                    if (scl_fall && !oe_q) begin
                        oe_d = 1'b1;
                    end else if (scl_fall) begin
                        oe_d  = 1'b0;
                        cnt_d = '0;
                        st_d  = als_pkg::BUS_RX;
                    end
                end
                als_pkg::BUS_TX: begin
                    if (scl_fall) begin
                        tx_d  = {tx_q[6:0], 1'b0};
                        cnt_d = cnt_q + 3'h1;
                        oe_d  = ~tx_q[6];
                        if (cnt_q == 3'h7) begin
                            oe_d  = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                            st_d  = als_pkg::BUS_TX_ACK;
                        end
                    end
                end
                als_pkg::BUS_TX_ACK: begin
                    if (scl_rise) begin
                        st_d = sda_s_q ? als_pkg::BUS_IDLE
                                       : als_pkg::BUS_TX_LOAD;
                    end
                end
                als_pkg::BUS_TX_LOAD: begin
                    if (scl_fall) begin
                        tx_d  = ld_byte;
                        oe_d  = ~ld_byte[7];
                        cnt_d = '0;
                        st_d  = als_pkg::BUS_TX;
                    end
                end
                default: begin
                    st_d = als_pkg::BUS_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // pointer survives stop so a later read continues from it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q      <= als_pkg::BUS_IDLE;
            sh_q      <= '0;
            tx_q      <= '0;
            cnt_q     <= '0;
            ptr_q     <= `ALS_PTR_RESET;
            rw_q      <= 1'b0;
            oe_q      <= 1'b0;
            got_ptr_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            sh_q      <= sh_d;
            tx_q      <= tx_d;
            cnt_q     <= cnt_d;
            ptr_q     <= ptr_d;
            rw_q      <= rw_d;
            oe_q      <= oe_d;
            got_ptr_q <= got_ptr_d;
        end
    end

endmodule

// File: pkg/als_cfg.svh
/*
 * constants for the ambient light readout: bus address, result register
 * pointers, reset values and conversion timing at the 200 MHz clock.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef ALS_CFG_SVH
`define ALS_CFG_SVH

// ******************************************************************
// bus addressing
// ******************************************************************
`define ALS_I2C_ADDR7     7'h13
`define ALS_REG_RES_HI    8'h85
`define ALS_REG_RES_LO    8'h86
`define ALS_PTR_RESET     8'h85
`define ALS_RESULT_RESET  16'h0000
`define ALS_UNMAPPED_BYTE 8'h00

// ******************************************************************
// timing
// ******************************************************************
`define ALS_CLK_MHZ       200
`define ALS_FRAME_MS      100
`define ALS_CONV_US       300
`define ALS_FRAME_CYC     (`ALS_FRAME_MS * 1000 * `ALS_CLK_MHZ)
`define ALS_CONV_CYC      (`ALS_CONV_US * `ALS_CLK_MHZ)
`define ALS_AVG_MAX       128

`endif

// File: pkg/als_pkg.sv
/*
 * types shared by the ambient light readout modules.
 * assumes als_cfg.svh supplies the numeric constants.
 */
package als_pkg;

    // ******************************************************************
    // carriers
    // ******************************************************************
    typedef struct packed {
        logic       enable;    // measurement requested
        logic       cont;      // continuous conversion select
        logic [2:0] avg_code;  // average over 2**avg_code conversions
    } als_ctrl_t;

    typedef struct packed {
        logic [15:0] value;
        logic        valid;    // one-cycle pulse on each new result
    } als_result_t;

    // ******************************************************************
    // state machines
    // ******************************************************************
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_WAIT} seq_state_t;

    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_RX, BUS_RX_ACK,
        BUS_TX, BUS_TX_ACK, BUS_TX_LOAD
    } bus_state_t;

endpackage

// File: verilog/als_conv_seq.sv
/*
 * conversion sequencer: times single conversions, accumulates samples
 * and publishes the averaged result per frame or per run.
 * assumes sample is a same-clock value valid at each conversion end.
 */
`timescale 1ns/100ps
`include "als_cfg.svh"

module als_conv_seq #(
    parameter int unsigned FRAME_CYC = `ALS_FRAME_CYC,
    parameter int unsigned CONV_CYC  = `ALS_CONV_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire als_pkg::als_ctrl_t ctrl,
    input  wire logic [15:0]        sample,
    output      als_pkg::als_result_t result,
    output      logic               conv_active
);

    localparam logic [24:0] FRAME_LAST = 25'(FRAME_CYC - 1);
    localparam logic [24:0] CONV_LAST  = 25'(CONV_CYC - 1);

    // ******************************************************************
    // averaging
    // ******************************************************************
    // a power-of-two count lets the average be a shift, no divider
    function automatic logic [15:0] avg(input logic [22:0] sum,
                                        input logic [2:0]  code);
        avg = 16'(sum >> code);
    endfunction

    als_pkg::seq_state_t  st_q, st_d;
    logic [24:0]          frame_q, frame_d;
    logic [24:0]          conv_q, conv_d;
    logic [7:0]           n_q, n_d;
    logic [22:0]          acc_q, acc_d;
    logic [22:0]          acc_sum;
    als_pkg::als_ctrl_t   mode_q, mode_d;
    als_pkg::als_result_t res_q, res_d;
    logic                 busy_q, busy_d;
    logic                 last_n;

    assign result      = res_q;
    assign conv_active = busy_q;

    // ******************************************************************
    // sequencing
    // ******************************************************************
    // mode and count are latched per run so a change never splits one
    always_comb begin
        st_d      = st_q;
        frame_d   = frame_q;
        conv_d    = conv_q;
        n_d       = n_q;
        acc_d     = acc_q;
        mode_d    = mode_q;
        res_d     = res_q;
        res_d.valid = 1'b0;
        busy_d    = busy_q;
        acc_sum   = acc_q + 23'(sample);
        last_n    = (n_q == 8'((9'h001 << mode_q.avg_code) - 9'h001));
        case (st_q)
            als_pkg::SEQ_IDLE: begin
                if (ctrl.enable) begin
                    st_d    = als_pkg::SEQ_CONV;
                    frame_d = '0;
                    conv_d  = '0;
                    n_d     = '0;
                    acc_d   = '0;
                    mode_d  = ctrl;
                    busy_d  = 1'b1;
                end
            end
            als_pkg::SEQ_CONV: begin
                frame_d = frame_q + 25'h0000001;
                conv_d  = conv_q + 25'h0000001;
                if (conv_q == CONV_LAST) begin
                    conv_d = '0;
                    acc_d  = acc_sum;
                    n_d    = n_q + 8'h01;
                    if (last_n && mode_q.cont) begin
                        res_d.value = avg(acc_sum, mode_q.avg_code);
                        res_d.valid = 1'b1;
                        acc_d   = '0;
                        n_d     = '0;
                        frame_d = '0;
                        mode_d  = ctrl;
                        if (!ctrl.enable) begin
                            st_d   = als_pkg::SEQ_IDLE;
                            busy_d = 1'b0;
                        end
                    end else if (last_n) begin
                        st_d   = als_pkg::SEQ_WAIT;
                        busy_d = 1'b0;
                    end
                end
            end
            als_pkg::SEQ_WAIT: begin
                frame_d = frame_q + 25'h0000001;
                if (frame_q == FRAME_LAST) begin
                    res_d.value = avg(acc_q, mode_q.avg_code);
                    res_d.valid = 1'b1;
                    st_d    = ctrl.enable ? als_pkg::SEQ_CONV
                                          : als_pkg::SEQ_IDLE;
                    busy_d  = ctrl.enable;
                    frame_d = '0;
                    conv_d  = '0;
                    n_d     = '0;
                    acc_d   = '0;
                    mode_d  = ctrl;
                end
            end
            default: st_d = als_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q    <= als_pkg::SEQ_IDLE;
            frame_q <= '0;
            conv_q  <= '0;
            n_q     <= '0;
            acc_q   <= '0;
            mode_q  <= '0;
            res_q   <= '{value: `ALS_RESULT_RESET, valid: 1'b0};
            busy_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            frame_q <= frame_d;
            conv_q  <= conv_d;
            n_q     <= n_d;
            acc_q   <= acc_d;
            mode_q  <= mode_d;
            res_q   <= res_d;
            busy_q  <= busy_d;
        end
    end

endmodule

// File: verification/als_readout_asserts.sv
/* checker for the ambient light readout top: pin timing, run length,
 * publish spacing and reset state.
 * assumes it is bound to als_readout and sees only its ports. */
`timescale 1ns/100ps
`include "als_cfg.svh"

module als_readout_asserts #(
    parameter int unsigned FRAME_CYC = `ALS_FRAME_CYC,
    parameter int unsigned CONV_CYC  = `ALS_CONV_CYC
) (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 scl_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire als_pkg::als_ctrl_t   ctrl,
    input wire als_pkg::als_result_t result,
    input wire logic                 conv_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ************
    // run tracking
    // ************
    logic        act_q, act_d, mode_q, mode_d, start;
    logic [2:0]  code_q, code_d;
    int unsigned since_q, since_d, run_q, run_d;

    // mode and count latched when conv_active rises, so only for runs that start from idle or wait
    always_comb begin
        start   = conv_active & ~act_q;
        act_d   = conv_active;
        mode_d  = start ? ctrl.cont : mode_q;
        code_d  = start ? ctrl.avg_code : code_q;
        since_d = start ? 1 : since_q + 1;
        run_d   = (start | result.valid) ? 1 : run_q + 1;
    end

    // counters cleared by reset so a mid-run reset starts clean
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            act_q   <= 1'b0;
            mode_q  <= 1'b0;
            code_q  <= 3'h0;
            since_q <= 0;
            run_q   <= 0;
        end else begin
            act_q   <= act_d;
            mode_q  <= mode_d;
            code_q  <= code_d;
            since_q <= since_d;
            run_q   <= run_d;
        end
    end

    // ************
    // properties
    // ************
    sequence s_std_publish;
        result.valid && !mode_q;
    endsequence
    sequence s_cont_publish;
        result.valid && mode_q;
    endsequence
    sequence s_std_done;
        $fell(conv_active) && !mode_q;
    endsequence

    a_frame_len: assert property (
        s_std_publish |-> since_q == FRAME_CYC)
        else $error("standard result not at frame end");
    a_conv_len: assert property (
        s_std_done |-> since_q == (CONV_CYC << code_q))
        else $error("standard run length wrong");
    a_run_len: assert property (
        s_cont_publish |-> run_q == (CONV_CYC << code_q))
        else $error("continuous publish spacing wrong");
    a_cont_no_gap: assert property (
        s_cont_publish and ctrl.enable && $past(ctrl.enable) |-> conv_active)
        else $error("gap between continuous runs");
    a_valid_pulse: assert property (result.valid |=> !result.valid)
        else $error("valid longer than one cycle");
    a_value_held: assert property ($changed(result.value) |-> result.valid)
        else $error("result changed without publish");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved while clock high");
    a_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
        (!sda_oe && !conv_active && !result.valid && result.value == 16'h0000))
        else $error("outputs not cleared by reset");
    c_cont_publish: cover property (s_cont_publish);
endmodule

bind als_readout als_readout_asserts #(
    .FRAME_CYC(FRAME_CYC),
    .CONV_CYC (CONV_CYC)
) i_als_readout_asserts (
    .clk        (clk),
    .rst_b      (rst_b),
    .scl_in     (scl_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .ctrl       (ctrl),
    .result     (result),
    .conv_active(conv_active)
);

// File: verification/i2c_host_model.sv
/* i2c host that sets the result pointer and reads result bytes.
 * assumes sda_line is the wired level with a pull-up; sda_pull high
 * means this host pulls the line low. scl stands high between frames. */
`timescale 1ns/100ps

module i2c_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output      logic scl,
    output      logic sda_pull
);
    int phase = 6; // clk cycles per scl half; the target needs >= 4

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ************
    // bit level
    // ************
    task automatic hold();
        repeat (phase) @(posedge clk);
    endtask
    // serves as start and repeated start alike
    task automatic start();
        @(posedge clk);
        sda_pull <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_pull <= 1'b1;
        hold();
        scl <= 1'b0;
        hold();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_pull <= 1'b0;
        hold();
    endtask
    // data moves 2 cycles after the fall so it never races the clock
    task automatic put_bit(input logic b);
        sda_pull <= ~b;
        hold();
        scl <= 1'b1;
        hold();
        scl <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic get_bit(output logic b);
        sda_pull <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        b = sda_line;
        scl <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // ************
    // byte level and transfers
    // ************
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(last);
    endtask
    // pointer write carries no data byte; stop is optional
    task automatic set_ptr(input logic [7:0] p, input logic with_stop,
                           output logic ok);
        logic a0;
        logic a1;
        start();
        send_byte(8'h26, a0);
        send_byte(p, a1);
        if (with_stop) stop();
        ok = a0 & a1;
    endtask
    // successive bytes without readdressing, last one refused
    task automatic read_n(input int n, output logic [15:0] d,
                          output logic ok);
        logic [7:0] v;
        d = 16'h0000;
        start();
        send_byte(8'h27, ok);
        for (int i = 0; i < n; i++) begin
            recv_byte(i == n - 1, v);
            d = {d[7:0], v};
        end
        stop();
    endtask
endmodule

// File: verification/tb_als_readout.sv
/* self-checking bench for als_readout: frame timing, averaging,
 * continuous runs and the i2c result read path.
 * assumes the checker and host model files are compiled before it. */
`timescale 1ns/100ps

module tb_als_readout;
    // ************
    // clock, reset and pins
    // ************
    localparam int unsigned FRAME = 3000; // shortened frame
    localparam int unsigned CONV  = 20;   // shortened conversion

    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 scl, host_pull, sda_line, sda_out, sda_oe;
    logic                 conv_active;
    logic [15:0]          sample = 16'h0000;
    logic [15:0]          expect_val = 16'h0000;
    als_pkg::als_ctrl_t   ctrl = '0;
    als_pkg::als_result_t result;
    int                   mismatches = 0;
    int                   cmp_count = 0;

    always #2.5 clk = ~clk;
    // pull-up line, low if either side pulls
    assign sda_line = ~host_pull & (sda_oe ? sda_out : 1'b1);

    als_readout #(.FRAME_CYC(FRAME), .CONV_CYC(CONV)) i_als_readout (
        .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl),
        .sample(sample), .result(result), .conv_active(conv_active));
    i2c_host_model i_i2c_host_model (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull));

    // ************
    // helpers
    // ************
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic go(input logic cont, input logic [2:0] code,
                      input logic [15:0] smp);
        int n;
        @(posedge clk);
        sample <= smp;
        ctrl   <= '{enable: 1'b1, cont: cont, avg_code: code};
        for (n = 0; n < 100 && conv_active !== 1'b1; n++) @(negedge clk);
        check("start", {15'h0, conv_active}, 16'h0001);
    endtask

    // ************
    // scenarios
    // ************
    // one frame; enable dropped at once so the frame runs alone
    task automatic test_std(input logic [2:0] code);
        int busy;
        int frame;
        busy = 0;
        frame = 0;
        expect_val = 16'ha550 | 16'(code);
        go(1'b0, code, expect_val);
        @(posedge clk);
        ctrl.enable <= 1'b0;
        for (int n = 1; n < 4000 && frame == 0; n++) begin
            @(negedge clk);
            if (busy == 0 && !conv_active) busy = n;
            if (result.valid === 1'b1) frame = n;
        end
        check("busy", 16'(busy), 16'(CONV << code));
        check("frame", 16'(frame), 16'(FRAME));
        check("value", result.value, expect_val);
        repeat (50) @(negedge clk);
        check("idle", {15'h0, conv_active}, 16'h0000);
        $display("test std code %0d done", code);
    endtask
    task automatic test_cont(input logic [2:0] code);
        int first;
        int second;
        int gap;
        first = 0;
        second = 0;
        gap = 0;
        go(1'b1, code, 16'h5a00 | 16'(code));
        for (int n = 1; n < 6000 && second == 0; n++) begin
            @(negedge clk);
            if (!conv_active) gap = 1;
            if (result.valid === 1'b1 && first != 0) second = n;
            if (result.valid === 1'b1 && first == 0) first = n;
        end
        check("run", 16'(first), 16'(CONV << code));
        check("next", 16'(second - first), 16'(CONV << code));
        check("gap", 16'(gap), 16'h0000);
        check("value", result.value, 16'h5a00 | 16'(code));
        @(posedge clk);
        ctrl.enable <= 1'b0;
        for (int n = 0; n < 6000 && conv_active; n++) @(negedge clk);
        check("stop", {15'h0, conv_active}, 16'h0000);
        $display("test cont code %0d done", code);
    endtask
    task automatic test_read(input int ph, input logic with_stop);
        logic        ok;
        logic [15:0] d;
        i_i2c_host_model.phase = ph;
        i_i2c_host_model.set_ptr(8'h85, with_stop, ok);
        check("ptr ack", {15'h0, ok}, 16'h0001);
        i_i2c_host_model.read_n(2, d, ok);
        check("addr ack", {15'h0, ok}, 16'h0001);
        check("pair", d, expect_val);
        i_i2c_host_model.read_n(1, d, ok);
        check("past end", d, 16'h0000);
        $display("test read phase %0d done", ph);
    endtask
    // pointer kept across stop; foreign address left unanswered
    task automatic test_split();
        logic        ok;
        logic [15:0] d;
        i_i2c_host_model.set_ptr(8'h85, 1'b1, ok);
        i_i2c_host_model.read_n(1, d, ok);
        check("high", d, {8'h00, expect_val[15:8]});
        i_i2c_host_model.read_n(1, d, ok);
        check("low", d, {8'h00, expect_val[7:0]});
        i_i2c_host_model.start();
        i_i2c_host_model.send_byte(8'h28, ok);
        i_i2c_host_model.stop();
        check("foreign", {15'h0, ok}, 16'h0000);
        $display("test split done");
    endtask
    task automatic test_reset();
        go(1'b1, 3'h2, 16'h1234);
        @(posedge clk);
        rst_b <= 1'b0;
        ctrl  <= '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check("rst run", {15'h0, conv_active}, 16'h0000);
        check("rst value", result.value, 16'h0000);
        $display("test reset done");
    endtask

    // ************
    // sequence and watchdog
    // ************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int c = 0; c < 8; c++) test_std(3'(c));
        test_read(6, 1'b1);
        test_read(12, 1'b0);
        test_split();
        for (int c = 0; c < 8; c++) test_cont(3'(c));
        test_reset();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        conclude();
    end
endmodule
